// File: fcsr_pkg.sv
// constants, types and command codes for the parallel flash host controller
package fcsr_pkg;
  localparam int AW = 19;
  localparam int DW = 16;
  // clock and bus timing, least times rounded up to whole cycles
  localparam int CLK_NS = 40;
  localparam int WP_NS = 45;
  localparam int ACC_NS = 70;
  localparam int HOLD_NS = 30;
  localparam logic [2:0] WP_CYC = 3'((WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] ACC_CYC = 3'((ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] HOLD_CYC = 3'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  // word-mode command addresses
  localparam logic [AW-1:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [AW-1:0] ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [AW-1:0] ADDR_ANY = 19'h00000;
  localparam logic [AW-1:0] ADDR_CFI = 19'h00055;
  localparam logic [AW-1:0] ADDR_PROT_LOW = 19'h00002;
  localparam int SECTOR_LSB = 12;
  // command codes, low data byte
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_BYPASS = 8'h20;
  localparam logic [7:0] CODE_AUTOSELECT = 8'h90;
  localparam logic [7:0] CODE_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CODE_CFI = 8'h98;
  // status bit positions on the data bus
  localparam int POLLING_STATUS_BIT = 7;
  localparam int FIRST_TOGGLE_BIT = 6;
  localparam int TIMEOUT_FLAG_BIT = 5;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROG = 4'h2, OP_SERASE = 4'h3,
    OP_CERASE = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_BYP_ENTER = 4'h7,
    OP_BYP_PROG = 4'h8, OP_BYP_EXIT = 4'h9, OP_PROT = 4'hA, OP_CFI = 4'hB
  } fcsr_op_t;

  typedef struct packed {
    logic wr;
    logic last;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
  } fcsr_cycle_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CYC = 3'h1, S_POLL_A = 3'h3, S_POLL_B = 3'h2,
    S_FINAL = 3'h6, S_RECOVER = 3'h7
  } fcsr_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0, E_SETUP = 2'h1, E_STROBE = 2'h3, E_HOLD = 2'h2
  } fcsr_eng_t;
endpackage : fcsr_pkg

// File: fcsr_bus_if.sv
// one bus cycle request and answer between sequencer and cycle engine
`timescale 1ns/1ps
interface fcsr_bus_if;
  import fcsr_pkg::*;
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic ack;
  logic [DW-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : fcsr_bus_if

// File: fcsr_cycle_engine.sv
// single read or write cycle on the flash pins
`timescale 1ns/1ps
module fcsr_cycle_engine
  import fcsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  fcsr_bus_if.engine bus,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [DW-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  fcsr_eng_t state_q;
  logic [2:0] cnt_q;
  logic wr_q;
  logic ack_q;
  logic [DW-1:0] rdata_q;

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  // cycle sequencing; ce rises after every cycle so each read is a fresh access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= E_IDLE;
      cnt_q <= 3'h0;
      wr_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
      flash_addr <= 19'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      ack_q <= 1'b0;
      unique case (state_q)
        E_IDLE: begin
          if (bus.req) begin
            flash_addr <= bus.addr;
            flash_dq_out <= bus.wdata;
            // drive the data bus only on writes
            flash_dq_oe_n <= ~bus.wr;
            flash_ce_n <= 1'b0;
            wr_q <= bus.wr;
            state_q <= E_SETUP;
          end
        end
        E_SETUP: begin
          // address settles one cycle ahead of the strobe
          if (wr_q) begin
            flash_we_n <= 1'b0;
          end else begin
            flash_oe_n <= 1'b0;
          end
          cnt_q <= 3'h0;
          state_q <= E_STROBE;
        end
        E_STROBE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == (wr_q ? WP_CYC : ACC_CYC) - 3'h1) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_q) begin
              rdata_q <= flash_dq_in;
            end
            cnt_q <= 3'h0;
            state_q <= E_HOLD;
          end
        end
        E_HOLD: begin
          // data still driven past the we rising edge, where the device latches it
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == HOLD_CYC - 3'h1) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            ack_q <= 1'b1;
            state_q <= E_IDLE;
          end
        end
      endcase
    end
  end

  a_write_drives_bus: assert property (
    @(posedge clk) disable iff (!reset_n)
    !flash_we_n |-> (!flash_ce_n && flash_oe_n && !flash_dq_oe_n))
    else $error("write strobe without chip select or data drive");

  a_we_pulse_width: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(flash_we_n) |-> !flash_we_n [*2] ##1 (flash_we_n && !flash_ce_n))
    else $error("write pulse width wrong");

  a_read_answer_time: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(flash_oe_n) |-> flash_dq_oe_n ##3 ack_q)
    else $error("read cycle answer late or early");
endmodule : fcsr_cycle_engine

// File: fcsr_host.sv
// host controller issuing command sequences to a parallel flash and polling status
// How it works
// - all sequence cycles are writes except array read and autoselect fourth cycle
// - host writes reset after autoselect and when timeout shows during status
// - bypass program only after bypass entry; leave by bypass reset or F0
// - after polling shows done, host reads once more for valid data
// - host may skip erase-timer check when sector commands stay under 50 us
`timescale 1ns/1ps
module fcsr_host
  import fcsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire fcsr_op_t cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_fail,
  output logic cmd_refused,
  output logic [DW-1:0] cmd_rdata,
  output logic bypass_active,
  output logic flash_ready,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [DW-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic ready_busy_n_pin
);
  fcsr_bus_if bus ();

  fcsr_state_t state_q;
  fcsr_op_t op_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [AW-1:0] poll_addr_q;
  logic [2:0] idx_q;
  logic pend_q;
  logic req_q;
  logic wr_q;
  logic [AW-1:0] baddr_q;
  logic [DW-1:0] bdata_q;
  logic tog1_q;
  logic recheck_q;
  logic finish_c;
  logic stopped_c;
  fcsr_cycle_t cur_c;

  // command value in the low byte, upper byte held at zero
  function automatic logic [DW-1:0] cmd_w(input logic [7:0] code);
    cmd_w = {8'h00, code};
  endfunction : cmd_w

  // ops that start an embedded algorithm and need polling
  function automatic logic poll_op(input fcsr_op_t op);
    poll_op = (op == OP_PROG) || (op == OP_BYP_PROG) || (op == OP_SERASE) ||
              (op == OP_CERASE);
  endfunction : poll_op

  function automatic logic refuse_f(input fcsr_op_t op, input logic byp);
    if (byp) begin
      refuse_f = !((op == OP_READ) || (op == OP_BYP_PROG) || (op == OP_BYP_EXIT) ||
                   (op == OP_RESET));
    end else begin
      refuse_f = (op == OP_BYP_PROG) || (op == OP_BYP_EXIT);
    end
  endfunction : refuse_f

  // bus cycle idx of the sequence for op; unlock pair leads the long sequences
  function automatic fcsr_cycle_t cyc_f(input fcsr_op_t op, input logic [2:0] idx,
                                        input logic [AW-1:0] ua, input logic [DW-1:0] ud);
    fcsr_cycle_t c;
    logic [AW-1:0] sa;
    sa = {ua[AW-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
    c = '{wr: 1'b1, last: 1'b0, a: ADDR_UNLOCK1, d: cmd_w(CODE_UNLOCK1)};
    if (idx == 3'h1 || idx == 3'h4) begin
      c.a = ADDR_UNLOCK2;
      c.d = cmd_w(CODE_UNLOCK2);
    end
    unique case (op)
      OP_READ: c = '{1'b0, 1'b1, ua, 16'h0000};
      OP_RESET: c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_RESET)};
      OP_SUSPEND: c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_SUSPEND)};
      OP_RESUME: c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_RESUME)};
      OP_CFI: c = '{1'b1, 1'b1, ADDR_CFI, cmd_w(CODE_CFI)};
      OP_PROG: begin
        if (idx == 3'h2) c.d = cmd_w(CODE_PROGRAM);
        if (idx == 3'h3) c = '{1'b1, 1'b1, ua, ud};
      end
      OP_SERASE, OP_CERASE: begin
        if (idx == 3'h2) c.d = cmd_w(CODE_ERASE_SETUP);
        if (idx == 3'h5) begin
          c = (op == OP_SERASE) ? '{1'b1, 1'b1, sa, cmd_w(CODE_SECTOR_ERASE)} :
                                  '{1'b1, 1'b1, ADDR_UNLOCK1, cmd_w(CODE_CHIP_ERASE)};
        end
      end
      OP_BYP_ENTER: begin
        if (idx == 3'h2) c = '{1'b1, 1'b1, ADDR_UNLOCK1, cmd_w(CODE_BYPASS)};
      end
      OP_BYP_PROG: begin
        c = (idx == 3'h0) ? '{1'b1, 1'b0, ADDR_ANY, cmd_w(CODE_PROGRAM)} :
                            '{1'b1, 1'b1, ua, ud};
      end
      OP_BYP_EXIT: begin
        c = (idx == 3'h0) ? '{1'b1, 1'b0, ADDR_ANY, cmd_w(CODE_AUTOSELECT)} :
                            '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_BYPASS_EXIT2)};
      end
      OP_PROT: begin
        if (idx == 3'h2) c.d = cmd_w(CODE_AUTOSELECT);
        if (idx == 3'h3) c = '{1'b0, 1'b0, sa | ADDR_PROT_LOW, 16'h0000};
        if (idx == 3'h4) c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_RESET)};
      end
      default: c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_RESET)};
    endcase
    cyc_f = c;
  endfunction : cyc_f

  assign bus.req = req_q;
  assign bus.wr = wr_q;
  assign bus.addr = baddr_q;
  assign bus.wdata = bdata_q;

  // cycle for the current state; polls read the address of the last command cycle (program, sector or 555 for chip erase)
  always_comb begin
    cur_c = cyc_f(op_q, idx_q, addr_q, data_q);
    if (state_q == S_POLL_A || state_q == S_POLL_B || state_q == S_FINAL) begin
      cur_c = '{1'b0, 1'b1, poll_addr_q, 16'h0000};
    end else if (state_q == S_RECOVER) begin
      cur_c = '{1'b1, 1'b1, ADDR_ANY, cmd_w(CODE_RESET)};
    end
    stopped_c = bus.rdata[FIRST_TOGGLE_BIT] == tog1_q;
  end

  assign finish_c = bus.ack && (((state_q == S_CYC) && cur_c.last && !poll_op(op_q)) ||
                                (state_q == S_FINAL) || (state_q == S_RECOVER));

  // cycle request: one pulse per bus cycle, next only after the answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      baddr_q <= 19'h00000;
      bdata_q <= 16'h0000;
    end else begin
      req_q <= 1'b0;
      if (bus.ack) begin
        pend_q <= 1'b0;
      end else if (state_q != S_IDLE && !pend_q) begin
        req_q <= 1'b1;
        pend_q <= 1'b1;
        wr_q <= cur_c.wr;
        baddr_q <= cur_c.a;
        bdata_q <= cur_c.d;
      end
    end
  end

  // sequencer and toggle-bit polling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      op_q <= OP_READ;
      addr_q <= 19'h00000;
      data_q <= 16'h0000;
      poll_addr_q <= 19'h00000;
      idx_q <= 3'h0;
      tog1_q <= 1'b0;
      recheck_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (cmd_valid && !refuse_f(cmd_op, bypass_active)) begin
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            idx_q <= 3'h0;
            recheck_q <= 1'b0;
            state_q <= S_CYC;
          end
        end
        S_CYC: begin
          if (bus.ack) begin
            idx_q <= idx_q + 3'h1;
            if (cur_c.last) begin
              state_q <= poll_op(op_q) ? S_POLL_A : S_IDLE;
              poll_addr_q <= cur_c.a;
            end
          end
        end
        S_POLL_A: begin
          if (bus.ack) begin
            tog1_q <= bus.rdata[FIRST_TOGGLE_BIT];
            state_q <= S_POLL_B;
          end
        end
        S_POLL_B: begin
          if (bus.ack) begin
            tog1_q <= bus.rdata[FIRST_TOGGLE_BIT];
            if (stopped_c) begin
              state_q <= S_FINAL;
            end else if (bus.rdata[TIMEOUT_FLAG_BIT]) begin
              // toggle may stop just as the flag rises, so check once more
              recheck_q <= 1'b1;
              if (recheck_q) state_q <= S_RECOVER;
            end
          end
        end
        S_FINAL, S_RECOVER: begin
          if (bus.ack) state_q <= S_IDLE;
        end
      endcase
    end
  end

  // user-side answers and mode tracking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_busy <= 1'b0;
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_rdata <= 16'h0000;
      bypass_active <= 1'b0;
      flash_ready <= 1'b0;
    end else begin
      flash_ready <= ready_busy_n_pin;
      cmd_done <= finish_c;
      cmd_refused <= (state_q == S_IDLE) && cmd_valid && refuse_f(cmd_op, bypass_active);
      if (state_q == S_IDLE && cmd_valid && !refuse_f(cmd_op, bypass_active)) begin
        cmd_busy <= 1'b1;
        cmd_fail <= 1'b0;
      end else if (finish_c) begin
        cmd_busy <= 1'b0;
      end
      if (state_q == S_RECOVER && bus.ack) cmd_fail <= 1'b1;
      if (bus.ack && !cur_c.wr && state_q != S_POLL_A && state_q != S_POLL_B) begin
        cmd_rdata <= bus.rdata;
      end
      if (finish_c && state_q == S_CYC && op_q == OP_BYP_ENTER) begin
        bypass_active <= 1'b1;
      end else if (finish_c && (op_q == OP_BYP_EXIT || op_q == OP_RESET ||
                                state_q == S_RECOVER)) begin
        bypass_active <= 1'b0;
      end
    end
  end

  fcsr_cycle_engine u_engine (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bus.engine),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  sequence s_toggle_stop;
    state_q == S_POLL_B && bus.ack && stopped_c;
  endsequence
  sequence s_timeout_fail;
    state_q == S_POLL_B && bus.ack && !stopped_c && bus.rdata[TIMEOUT_FLAG_BIT] && recheck_q;
  endsequence

  a_final_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_toggle_stop |=> state_q == S_FINAL ##[1:20] (cmd_done && !cmd_fail))
    else $error("no extra read after toggle stop");

  a_fail_reset: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_timeout_fail |=> state_q == S_RECOVER ##[1:20] (cmd_done && cmd_fail))
    else $error("timeout not followed by reset");

  a_autosel_reset: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == S_CYC && op_q == OP_PROT && bus.ack && idx_q == 3'h3)
    |=> (idx_q == 3'h4 && cur_c.wr && cur_c.d == cmd_w(CODE_RESET)))
    else $error("autoselect not left by reset");

  a_byp_refuse: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == S_IDLE && cmd_valid && cmd_op == OP_BYP_PROG && !bypass_active)
    |=> cmd_refused && state_q == S_IDLE)
    else $error("bypass program taken outside bypass");

  a_byp_exit: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(bypass_active) |-> (op_q == OP_BYP_EXIT || op_q == OP_RESET || cmd_fail))
    else $error("bypass left without reset command");

  a_erase_poll: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == S_CYC && op_q == OP_SERASE && bus.ack && cur_c.last)
    |=> state_q == S_POLL_A && poll_addr_q[SECTOR_LSB-1:0] == 12'h000)
    else $error("sector erase not followed by polling");
endmodule : fcsr_host

// File: fcsr_flash_model.sv
// behavioural parallel flash device answering the host controller
`timescale 1ns/1ps
module fcsr_flash_model
  import fcsr_pkg::*;
#(
  // algorithm times in 10 ns ticks
  parameter int T_PROG = 80,
  parameter int T_PROT = 100,
  parameter int T_ERASE = 400,
  parameter int T_EPROT = 10000,
  parameter logic [6:0] PROT_SECT = 7'h05,
  parameter logic [15:0] QUERY_WORD = 16'h0051 // arbitrary value
) (
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic fail_en,
  output logic [DW-1:0] dev_dq,
  output logic rb_low
);
  typedef enum logic [2:0] {M_ARRAY, M_AUTO, M_CFI, M_PROG, M_ERASE, M_SUSP, M_FAIL} fcsr_mode_t;
  logic [15:0] mem [int];
  fcsr_mode_t mode = M_ARRAY;
  int cyc = 0;
  int cnt = 0;
  logic byp = 0, ers = 0, tgl = 0, tgl2 = 0, prot = 0;
  logic [AW-1:0] a_q = '0, pa = '0;
  logic [15:0] pd = '0, rd_q = '0, last_q = '0;
  logic [6:0] es = '0;
  wire wr_n = flash_ce_n | flash_we_n;
  wire rd_n = flash_ce_n | flash_oe_n;

  function automatic logic [15:0] peek(input logic [AW-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction : peek

  // program runs, protected sector only shows status
  task automatic start_prog(input logic [AW-1:0] a, input logic [15:0] d);
    cyc = 0;
    pa = a;
    pd = d;
    prot = (a[18:12] == PROT_SECT);
    cnt = prot ? T_PROT : T_PROG;
    mode = fail_en ? M_FAIL : M_PROG;
  endtask : start_prog

  // sector picked by the upper field alone
  task automatic start_erase(input logic [AW-1:0] a, input logic [7:0] c);
    cyc = 0;
    if (c != CODE_SECTOR_ERASE && c != CODE_CHIP_ERASE) return;
    ers = (c == CODE_CHIP_ERASE);
    es = a[18:12];
    prot = !ers && es == PROT_SECT;
    cnt = prot ? T_EPROT : T_ERASE;
    mode = M_ERASE;
  endtask : start_erase

  // write cycles decode low byte and low address only
  task automatic write_cycle(input logic [AW-1:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic [10:0] la;
    c = d[7:0];
    la = a[10:0];
    // busy device takes only reset after failure or suspend during an unprotected erase
    if (mode inside {M_FAIL, M_PROG, M_ERASE}) begin
      if (mode == M_FAIL && c == CODE_RESET) mode = M_ARRAY;
      else if (mode == M_ERASE && !prot && c == CODE_SUSPEND) mode = M_SUSP;
      return;
    end
    if (mode == M_SUSP && c == CODE_RESUME) begin
      mode = M_ERASE;
      return;
    end
    if (c == CODE_RESET) begin
      mode = (mode == M_SUSP) ? M_SUSP : M_ARRAY;
      byp = 0;
      cyc = 0;
      return;
    end
    if (byp) begin
      if (cyc == 0 && c == CODE_PROGRAM) cyc = 3;
      else if (cyc == 0 && c == CODE_AUTOSELECT) cyc = 9;
      else if (cyc == 9 && c == CODE_BYPASS_EXIT2) byp = 0;
      else if (cyc == 3) start_prog(a, d);
      if (cyc != 3 && cyc != 9 || c == CODE_BYPASS_EXIT2) cyc = 0;
      return;
    end
    case (cyc)
      0: begin
        if (la == 11'h555 && c == CODE_UNLOCK1) cyc = 1;
        // query only from array or autoselect
        else if (la == 11'h055 && c == CODE_CFI && mode inside {M_ARRAY, M_AUTO}) mode = M_CFI;
      end
      1: cyc = (la == 11'h2AA && c == CODE_UNLOCK2) ? 2 : 0;
      2: begin
        cyc = 0;
        if (la == 11'h555 && c == CODE_PROGRAM) cyc = 3;
        if (la == 11'h555 && c == CODE_ERASE_SETUP) cyc = 4;
        if (la == 11'h555 && c == CODE_AUTOSELECT) mode = M_AUTO;
        if (la == 11'h555 && c == CODE_BYPASS) byp = 1;
      end
      3: start_prog(a, d);
      4: cyc = (la == 11'h555 && c == CODE_UNLOCK1) ? 5 : 0;
      5: cyc = (la == 11'h2AA && c == CODE_UNLOCK2) ? 6 : 0;
      // one selection per erase; later lone confirm cycles meet the busy path
      6: start_erase(a, c);
      default: cyc = 0;
    endcase
  endtask : write_cycle

  task automatic finish_alg();
    int ks[$];
    if (mode == M_PROG && !prot) mem[int'(pa)] = peek(pa) & pd;
    if (mode == M_ERASE && !prot) begin
      foreach (mem[k]) if (ers ? k[18:12] != PROT_SECT : k[18:12] == es) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
    end
    mode = M_ARRAY;
  endtask : finish_alg

  // address on the later falling strobe
  always @(negedge wr_n) a_q = flash_addr;
  // data on the earlier rising strobe
  always @(posedge wr_n) write_cycle(a_q, flash_dq_out);

  // algorithm timer, frozen while suspended so resume continues
  initial forever begin
    #10;
    if ((mode == M_PROG || mode == M_ERASE) && cnt > 0) begin
      cnt--;
      if (cnt == 0) finish_alg();
    end
  end

  function automatic logic [15:0] read_word(input logic [AW-1:0] a);
    logic ins;
    ins = ers ? a[18:12] != PROT_SECT : a[18:12] == es;
    case (mode)
      // inverted bit, toggle, timeout while programming
      M_PROG, M_FAIL: begin
        tgl = ~tgl;
        return {8'h00, ~pd[7], tgl, mode == M_FAIL, 5'h00};
      end
      M_ERASE: begin
        tgl = ~tgl;
        tgl2 = ins ? ~tgl2 : tgl2;
        return {8'h00, 1'b0, tgl, 2'h0, 1'b1, tgl2, 2'h0};
      end
      // suspended sector shows 1, toggle bit stands
      M_SUSP: if (ins) begin
        tgl2 = ~tgl2;
        return {8'h00, 1'b1, tgl, 3'h0, tgl2, 2'h0};
      end
      M_AUTO: if (a[1:0] == 2'h2) return {15'h0000, a[18:12] == PROT_SECT};
      M_CFI: return QUERY_WORD;
      default: ;
    endcase
    return peek(a);
  endfunction : read_word

  // read word frozen at strobe start; released bus shows the inverse
  always @(negedge rd_n) rd_q = read_word(flash_addr);
  always @(posedge rd_n) last_q = rd_q;
  assign dev_dq = !rd_n ? rd_q : ~last_q;
  // open drain pulled low while an algorithm runs and after a failure until reset
  assign rb_low = (mode == M_PROG || mode == M_ERASE || mode == M_FAIL);
endmodule : fcsr_flash_model

// File: tb_flash_cmd_status_reporting.sv
// self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
module tb_flash_cmd_status_reporting;
  import fcsr_pkg::*;
  localparam logic [6:0] PS = 7'h05;
  logic clk = 0, reset_n = 0, cmd_valid = 0, fail_en = 0, got_ref, saw_busy;
  fcsr_op_t cmd_op = OP_READ;
  logic [AW-1:0] cmd_addr = '0, flash_addr, a;
  logic [DW-1:0] cmd_data = '0, cmd_rdata, flash_dq_out, dev_dq;
  logic cmd_busy, cmd_done, cmd_fail, cmd_refused, bypass_active, flash_ready;
  logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, rb_low;
  // pull-up on the shared open drain wire
  wire ready_busy_n_pin = rb_low ? 1'b0 : 1'b1;
  int n_errors = 0, n_checks = 0, seed = 32'hd3b5;
  logic [15:0] exp_mem [int];

  fcsr_host dut_u (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_fail(cmd_fail), .cmd_refused(cmd_refused), .cmd_rdata(cmd_rdata),
    .bypass_active(bypass_active), .flash_ready(flash_ready), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(dev_dq),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .ready_busy_n_pin(ready_busy_n_pin));
  // an undriven data bus shows the inverse, so a write without drive lands wrong
  fcsr_flash_model #(.PROT_SECT(PS)) dev_u (.flash_addr(flash_addr),
    .flash_dq_out(flash_dq_oe_n ? ~flash_dq_out : flash_dq_out), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .fail_en(fail_en), .dev_dq(dev_dq), .rb_low(rb_low));

  initial forever #20 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  function automatic logic [15:0] exp_rd(input logic [AW-1:0] x);
    return exp_mem.exists(int'(x)) ? exp_mem[int'(x)] : 16'hFFFF;
  endfunction : exp_rd

  // one request, then wait for done or refusal under a bound
  task automatic run(input fcsr_op_t op, input logic [AW-1:0] x, input logic [15:0] d);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= x;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    got_ref = 1'b0;
    saw_busy = 1'b0;
    for (i = 0; i < 20000; i++) begin
      #1;
      if (flash_ready === 1'b0) saw_busy = 1'b1;
      if (cmd_refused === 1'b1) got_ref = 1'b1;
      if (i == 0 && !got_ref) chk_flag(cmd_busy, 1'b1);
      if (cmd_done === 1'b1 || got_ref) break;
      @(posedge clk);
    end
    if (i == 20000) chk_flag(1'b0, 1'b1);
    chk_flag(cmd_busy, 1'b0);
  endtask : run

  task automatic rd(input logic [AW-1:0] x, input logic [15:0] e);
    run(OP_READ, x, 16'h0000);
    chk_word(cmd_rdata, e);
  endtask : rd

  // program and poll; device busy must have shown on the pin
  task automatic prog(input fcsr_op_t op, input logic [AW-1:0] x, input logic [15:0] d);
    if (!fail_en && x[18:12] != PS) exp_mem[int'(x)] = exp_rd(x) & d;
    run(op, x, d);
    chk_flag(saw_busy, 1'b1);
    chk_flag(cmd_fail, fail_en);
    if (!fail_en) chk_word(cmd_rdata, exp_rd(x));
    rd(x, exp_rd(x));
  endtask : prog

  task automatic erase(input fcsr_op_t op, input logic [6:0] s);
    int ks[$];
    foreach (exp_mem[k]) if (op == OP_CERASE ? k[18:12] != PS : k[18:12] == s) ks.push_back(k);
    foreach (ks[i]) exp_mem.delete(ks[i]);
    run(op, {s, 12'h000}, 16'h0000);
    chk_flag(saw_busy, 1'b1);
    chk_word(cmd_rdata, exp_rd({s, 12'h000}));
  endtask : erase

  // hang guard well above the expected run length
  initial begin
    #2000000;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(19'h10123, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      a = 19'($random(seed));
      a[18:12] = 7'h10 | 7'(i);
      prog(OP_PROG, a, 16'($random(seed)));
    end
    prog(OP_PROG, {7'h10, 12'h000}, 16'hA5A5);
    prog(OP_PROG, {PS, 12'h123}, 16'h0000);
    $display("test program done");
    run(OP_PROT, {PS, 12'h000}, 16'h0000);
    chk_word(cmd_rdata, 16'h0001);
    run(OP_PROT, {7'h11, 12'h000}, 16'h0000);
    chk_word(cmd_rdata, 16'h0000);
    rd({PS, 12'h002}, 16'hFFFF);
    run(OP_CFI, 19'h00000, 16'h0000);
    rd(19'h00000, 16'h0051);
    run(OP_RESET, 19'h00000, 16'h0000);
    rd(19'h00000, 16'hFFFF);
    $display("test autoselect done");
    erase(OP_SERASE, 7'h10);
    rd({7'h10, 12'h000}, 16'hFFFF);
    erase(OP_SERASE, PS);
    $display("test erase done");
    run(OP_BYP_PROG, 19'h12000, 16'h1234);
    chk_flag(got_ref, 1'b1);
    run(OP_BYP_ENTER, 19'h00000, 16'h0000);
    chk_flag(bypass_active, 1'b1);
    run(OP_PROG, 19'h12000, 16'h1234);
    chk_flag(got_ref, 1'b1);
    prog(OP_BYP_PROG, 19'h12010, 16'($random(seed)));
    run(OP_BYP_EXIT, 19'h00000, 16'h0000);
    chk_flag(bypass_active, 1'b0);
    run(OP_BYP_EXIT, 19'h00000, 16'h0000);
    chk_flag(got_ref, 1'b1);
    $display("test bypass done");
    // blocking, so the expected-memory update in prog already sees the failure
    fail_en = 1'b1;
    prog(OP_PROG, 19'h13000, 16'h0F0F);
    fail_en = 1'b0;
    chk_flag(flash_ready, 1'b1);
    run(OP_SUSPEND, 19'h00000, 16'h0000);
    run(OP_RESUME, 19'h00000, 16'h0000);
    chk_flag(cmd_fail, 1'b0);
    erase(OP_CERASE, 7'h00);
    rd(19'h12010, 16'hFFFF);
    $display("test fail and chip erase done");
    finish_test();
  end
endmodule : tb_flash_cmd_status_reporting
